// ===== hdlc_ovh_consts.vh
`ifndef HDLC_OVH_CONSTS_VH
`define HDLC_OVH_CONSTS_VH
`define ADR_CTRL 8'h00
`define ADR_THRESH 8'h04
`define ADR_TXDATA 8'h08
`define ADR_STATUS 8'h0C
`define CTRL_START_EN 0
`define CTRL_FILL_ONES 1
`define CTRL_TX_FCS 2
`define CTRL_FCS_ERR 3
`define CTRL_TX_REORD 4
`define CTRL_TX_INV 5
`define CTRL_RX_INV 6
`define CTRL_RX_FCS 7
`define CTRL_RX_REORD 8
`define CTRL_RST 9'h000
`define THRESH_RST 9'h010
`define TXD_END 8
`define ST_EMPTY 0
`define ST_FULL 1
`define ST_SPACE 2
`define ST_OVF 3
`define ST_UNF 4
`define ST_LEVEL 8
`define FLAG_BYTE 8'h7E
`define ABORT_BYTE 8'hFF
`define CRC_PRESET 16'hFFFF
`define CRC_POLY_R 16'h8408
`define CRC_GOOD 16'hF0B8
`define ONES_FILL_MIN 5'd15
`define FLAG_FILL_MIN 5'd2
`define START_LEVEL 2
`define RX_MIN_BITS 5'd16
`endif

// ===== hdlc_overhead_packet_controller.v
`timescale 1ns/1ps
`include "hdlc_ovh_consts.vh"
`default_nettype none
module hdlc_overhead_packet_controller #(
   parameter DEPTH = 256,
   parameter AW = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire tx_bit_req_i,
   output reg tx_bit_o,
   input wire rx_bit_valid_i,
   input wire rx_bit_i,
   output reg [7:0] rx_buffer_byte_o,
   output reg rx_valid_o,
   output reg rx_start_o,
   output reg rx_end_o,
   output reg rx_abort_o,
   output reg rx_fcs_err_o
);
   localparam [3:0] ST_FILL = 4'b0001;
   localparam [3:0] ST_DATA = 4'b0010;
   localparam [3:0] ST_FCS = 4'b0100;
   localparam [3:0] ST_END = 4'b1000;

   function [7:0] rev8;
      input [7:0] v;
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1)
            rev8[k] = v[7-k];
      end
   endfunction

   function [15:0] crc_step;
      input [15:0] c;
      input b;
      begin
         crc_step = (c >> 1) ^ ((c[0] ^ b) ? `CRC_POLY_R : 16'h0000);
      end
   endfunction

   // Register bus
   reg [8:0] ctrl_reg, thresh_reg;
   reg ovf_reg, unf_reg;
   reg [8:0] mem [0:DEPTH-1];
   reg [AW-1:0] wptr_reg, rptr_reg;
   reg [AW:0] cnt_reg;
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i;
   wire [AW:0] free_cnt = DEPTH[AW:0] - cnt_reg;
   wire tx_empty = (cnt_reg == {(AW+1){1'b0}});
   wire tx_full = (cnt_reg == DEPTH[AW:0]);
   wire push = wr & (wb_adr_i == `ADR_TXDATA) & wb_sel_i[0] & ~tx_full;
   wire ovf_set = wr & (wb_adr_i == `ADR_TXDATA) & wb_sel_i[0] & tx_full;
   wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [15:0] ctrl_w = ({7'h00, ctrl_reg} & ~wmask) | (wb_dat_i[15:0] & wmask);
   wire [15:0] th_w = ({7'h00, thresh_reg} & ~wmask) | (wb_dat_i[15:0] & wmask);
   reg [31:0] rd_data;

   // Transmit processor
   reg [3:0] st_reg, st_next;
   reg [15:0] sh_reg, crc_reg, u_sh;
   reg [4:0] nb_reg, fcnt_reg, fcnt_next, u_nb;
   reg [2:0] ones_reg;
   reg stf_reg, u_stf, u_crc, pop_c, unf_c, preset_c;
   wire fill_ones = ctrl_reg[`CTRL_FILL_ONES];
   wire can_start = (cnt_reg >= `START_LEVEL) & ctrl_reg[`CTRL_START_EN];
   wire [4:0] fill_min = fill_ones ? `ONES_FILL_MIN : `FLAG_FILL_MIN;
   wire go = can_start & (fcnt_reg >= fill_min);
   wire stuff_now = stf_reg & (ones_reg == 3'd5);
   wire take = tx_bit_req_i & ~stuff_now;
   wire pop = take & pop_c;
   wire [8:0] head = mem[rptr_reg];
   wire [7:0] head_ord = ctrl_reg[`CTRL_TX_REORD] ? rev8(head[7:0]) : head[7:0];
   wire tbit = u_sh[0];
   wire unf_set = take & unf_c;

   always @* begin
      u_sh = sh_reg;
      u_nb = nb_reg;
      u_stf = stf_reg;
      // Last data byte still shifts out while the state already reads ST_FCS
      u_crc = stf_reg & (st_reg != ST_END);
      st_next = st_reg;
      fcnt_next = fcnt_reg;
      pop_c = 1'b0;
      unf_c = 1'b0;
      preset_c = 1'b0;
      if (nb_reg == 5'd0) begin
         u_nb = 5'd8;
         u_stf = 1'b0;
         u_crc = 1'b0;
         u_sh = {8'h00, `FLAG_BYTE};
         case (st_reg)
            ST_FILL: begin
               if (go) begin
                  preset_c = 1'b1;
                  st_next = ST_DATA;
               end else begin
                  if (fill_ones) begin
                     u_nb = 5'd1;
                     u_sh = 16'h0001;
                  end
                  if (fcnt_reg != 5'h1F)
                     fcnt_next = fcnt_reg + 5'd1;
               end
            end
            ST_DATA: begin
               if (tx_empty) begin
                  unf_c = 1'b1;
                  u_sh = {8'h00, `ABORT_BYTE};
                  st_next = ST_FILL;
                  fcnt_next = 5'd0;
               end else begin
                  pop_c = 1'b1;
                  u_sh = {8'h00, head_ord};
                  u_stf = 1'b1;
                  u_crc = 1'b1;
                  if (head[`TXD_END])
                     st_next = ctrl_reg[`CTRL_TX_FCS] ? ST_FCS : ST_END;
               end
            end
            ST_FCS: begin
               u_nb = 5'd16;
               u_stf = 1'b1;
               u_sh = ctrl_reg[`CTRL_FCS_ERR] ? crc_reg : ~crc_reg;
               st_next = ST_END;
            end
            ST_END: begin
               st_next = ST_FILL;
               // End flag counts as first fill flag when filling with flags (ones fill restarts at zero); back-to-back gives two flags
               if (can_start)
                  fcnt_next = 5'h1F;
               else
                  fcnt_next = fill_ones ? 5'd0 : 5'd1;
            end
            default: st_next = ST_FILL;
         endcase
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= ST_FILL;
         sh_reg <= 16'h0000;
         nb_reg <= 5'd0;
         stf_reg <= 1'b0;
         ones_reg <= 3'd0;
         fcnt_reg <= 5'h1F;
         crc_reg <= `CRC_PRESET;
         tx_bit_o <= 1'b1;
      end else if (tx_bit_req_i) begin
         if (stuff_now) begin
            tx_bit_o <= ctrl_reg[`CTRL_TX_INV];
            ones_reg <= 3'd0;
         end else begin
            tx_bit_o <= tbit ^ ctrl_reg[`CTRL_TX_INV];
            sh_reg <= u_sh >> 1;
            nb_reg <= u_nb - 5'd1;
            stf_reg <= u_stf;
            st_reg <= st_next;
            fcnt_reg <= fcnt_next;
            ones_reg <= (u_stf & tbit) ? ones_reg + 3'd1 : 3'd0;
            if (preset_c)
               crc_reg <= `CRC_PRESET;
            else if (u_crc)
               crc_reg <= crc_step(crc_reg, tbit);
         end
      end
   end

   always @* begin
      rd_data = 32'h00000000;
      if (wb_adr_i == `ADR_CTRL)
         rd_data[8:0] = ctrl_reg;
      else if (wb_adr_i == `ADR_THRESH)
         rd_data[8:0] = thresh_reg;
      else if (wb_adr_i == `ADR_STATUS) begin
         rd_data[`ST_EMPTY] = tx_empty;
         rd_data[`ST_FULL] = tx_full;
         rd_data[`ST_SPACE] = (free_cnt >= thresh_reg);
         rd_data[`ST_OVF] = ovf_reg;
         rd_data[`ST_UNF] = unf_reg;
         rd_data[`ST_LEVEL+AW:`ST_LEVEL] = cnt_reg;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_reg <= `CTRL_RST;
         thresh_reg <= `THRESH_RST;
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
         wptr_reg <= {AW{1'b0}};
         rptr_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end else begin
         wb_ack_o <= req;
         if (req & ~wb_we_i)
            wb_dat_o <= rd_data;
         if (wr & (wb_adr_i == `ADR_CTRL))
            ctrl_reg <= ctrl_w[8:0];
         if (wr & (wb_adr_i == `ADR_THRESH))
            thresh_reg <= th_w[8:0];
         // Write one clears; a new event in the same cycle wins
         if (ovf_set)
            ovf_reg <= 1'b1;
         else if (wr & (wb_adr_i == `ADR_STATUS) & wb_sel_i[0] & wb_dat_i[`ST_OVF])
            ovf_reg <= 1'b0;
         if (unf_set)
            unf_reg <= 1'b1;
         else if (wr & (wb_adr_i == `ADR_STATUS) & wb_sel_i[0] & wb_dat_i[`ST_UNF])
            unf_reg <= 1'b0;
         if (push) begin
            mem[wptr_reg] <= {wb_dat_i[`TXD_END] & wb_sel_i[1], wb_dat_i[7:0]};
            wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop)
            rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
         if (push & ~pop)
            cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
         else if (pop & ~push)
            cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   // Receive processor; data runs seven bits behind the flag hunter,
   // so the last data bit is taken just before a closing flag completes
   reg [7:0] hist_reg, sr_reg, d0_reg, d1_reg, d2_reg;
   reg [3:0] hn_reg;
   reg [2:0] rones_reg, dones_reg, bc_reg, dv_reg;
   reg inp_reg, started_reg;
   reg [4:0] pbits_reg;
   reg [15:0] rcrc_reg;
   wire rb = rx_bit_i ^ ctrl_reg[`CTRL_RX_INV];
   wire [7:0] hist_n = {hist_reg[6:0], rb};
   wire db = hist_reg[6];
   wire rx_fcs = ctrl_reg[`CTRL_RX_FCS];
   wire [7:0] slot = rx_fcs ? d2_reg : d0_reg;
   wire slotv = rx_fcs ? dv_reg[2] : dv_reg[0];
   wire [7:0] nbyte = {db, sr_reg[7:1]};
   wire [7:0] nbyte_ord = ctrl_reg[`CTRL_RX_REORD] ? rev8(nbyte) : nbyte;

   always @(posedge clk_i) begin
      if (rst_i) begin
         hist_reg <= 8'h00;
         hn_reg <= 4'd0;
         rones_reg <= 3'd0;
         dones_reg <= 3'd0;
         inp_reg <= 1'b0;
         started_reg <= 1'b0;
         bc_reg <= 3'd0;
         sr_reg <= 8'h00;
         pbits_reg <= 5'd0;
         rcrc_reg <= `CRC_PRESET;
         d0_reg <= 8'h00;
         d1_reg <= 8'h00;
         d2_reg <= 8'h00;
         dv_reg <= 3'b000;
         rx_buffer_byte_o <= 8'h00;
         rx_valid_o <= 1'b0;
         rx_start_o <= 1'b0;
         rx_end_o <= 1'b0;
         rx_abort_o <= 1'b0;
         rx_fcs_err_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (rx_bit_valid_i) begin
            hist_reg <= hist_n;
            hn_reg <= (hn_reg == 4'd8) ? hn_reg : hn_reg + 4'd1;
            rones_reg <= rb ? ((rones_reg == 3'd7) ? rones_reg : rones_reg + 3'd1) : 3'd0;
            if (hist_n == `FLAG_BYTE) begin
               if (inp_reg & (pbits_reg >= `RX_MIN_BITS)) begin
                  rx_valid_o <= 1'b1;
                  rx_start_o <= ~started_reg;
                  rx_end_o <= 1'b1;
                  rx_buffer_byte_o <= slot;
                  rx_abort_o <= (bc_reg != 3'd0) | ~slotv;
                  rx_fcs_err_o <= rx_fcs & (rcrc_reg != `CRC_GOOD);
               end
               inp_reg <= 1'b1;
               hn_reg <= 4'd0;
               bc_reg <= 3'd0;
               pbits_reg <= 5'd0;
               dones_reg <= 3'd0;
               started_reg <= 1'b0;
               dv_reg <= 3'b000;
               rcrc_reg <= `CRC_PRESET;
            end else if (inp_reg & rb & (rones_reg == 3'd6)) begin
               inp_reg <= 1'b0;
               if (started_reg) begin
                  rx_valid_o <= 1'b1;
                  rx_start_o <= 1'b0;
                  rx_end_o <= 1'b1;
                  rx_abort_o <= 1'b1;
                  rx_fcs_err_o <= 1'b0;
                  rx_buffer_byte_o <= 8'h00;
               end
            end else if (inp_reg & (hn_reg >= 4'd7)) begin
               if ((dones_reg == 3'd5) & ~db)
                  dones_reg <= 3'd0;
               else begin
                  dones_reg <= db ? ((dones_reg == 3'd5) ? dones_reg : dones_reg + 3'd1) : 3'd0;
                  sr_reg <= nbyte;
                  bc_reg <= bc_reg + 3'd1;
                  rcrc_reg <= crc_step(rcrc_reg, db);
                  if (pbits_reg != 5'h1F)
                     pbits_reg <= pbits_reg + 5'd1;
                  if (bc_reg == 3'd7) begin
                     if (slotv) begin
                        rx_valid_o <= 1'b1;
                        rx_start_o <= ~started_reg;
                        rx_end_o <= 1'b0;
                        rx_abort_o <= 1'b0;
                        rx_fcs_err_o <= 1'b0;
                        rx_buffer_byte_o <= slot;
                        started_reg <= 1'b1;
                     end
                     d0_reg <= nbyte_ord;
                     d1_reg <= d0_reg;
                     d2_reg <= d1_reg;
                     dv_reg <= {dv_reg[1:0], 1'b1};
                  end
               end
            end
         end
      end
   end
endmodule // hdlc_overhead_packet_controller
`default_nettype wire

// ===== hdlc_ovh_props.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_ovh_props (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire tx_bit_req_i,
   input wire tx_bit_o,
   input wire rx_bit_valid_i,
   input wire rx_valid_o,
   input wire rx_end_o,
   input wire rx_fcs_err_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   a_empty_level: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C
      |-> wb_dat_o[0] == (wb_dat_o[16:8] == 9'h000)) else $error("empty flag");
   a_full_level: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C
      |-> wb_dat_o[1] == (wb_dat_o[16:8] == 9'h100)) else $error("full flag");
   a_tx_hold: assert property (!tx_bit_req_i |=> $stable(tx_bit_o))
      else $error("line bit moved without request");
   a_rx_cause: assert property (rx_valid_o |-> $past(rx_bit_valid_i))
      else $error("byte without line bit");
   a_fcs_on_end: assert property (rx_valid_o && rx_fcs_err_o |-> rx_end_o)
      else $error("check error off packet end");
   a_reset_idle: assert property ($past(rst_i) |-> tx_bit_o && !wb_ack_o && !rx_valid_o)
      else $error("outputs not idle after reset");
endmodule // hdlc_ovh_props
bind hdlc_overhead_packet_controller hdlc_ovh_props u_props (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_bit_req_i(tx_bit_req_i),
   .tx_bit_o(tx_bit_o), .rx_bit_valid_i(rx_bit_valid_i), .rx_valid_o(rx_valid_o),
   .rx_end_o(rx_end_o), .rx_fcs_err_o(rx_fcs_err_o));
`default_nettype wire

// ===== framer_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module framer_link_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] gap_i,
   input wire logic line_i,
   output logic req_o,
   output logic rxv_o,
   output logic rxb_o
);
   logic [3:0] cnt_reg;
   logic pend_reg;
   // Overhead slots every gap_i+1 cycles, sent bit looped back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 4'h0;
         req_o <= 1'b0;
         pend_reg <= 1'b0;
         rxv_o <= 1'b0;
         rxb_o <= 1'b0;
      end else begin
         req_o <= (cnt_reg == gap_i);
         cnt_reg <= (cnt_reg >= gap_i) ? 4'h0 : cnt_reg + 4'h1;
         pend_reg <= req_o;
         rxv_o <= pend_reg;
         // Toggles between slots so a stale bit never looks valid
         rxb_o <= pend_reg ? line_i : ~rxb_o;
      end
   end
endmodule // framer_link_model
`default_nettype wire

// ===== hdlc_overhead_packet_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hdlc_overhead_packet_controller_tb;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF, gap = 4'h0;
   logic [31:0] wdat = 32'h0, r;
   wire [31:0] rdat;
   wire [7:0] rbyte;
   wire ack, txb, req, rxv, rxb, vld, st, en, ab, fe;
   int error_cnt = 0, n_compared = 0, cyc_cnt = 0;
   logic [11:0] q[$];
   logic [11:0] e;
   // Rows: control word, then expected check error on last byte
   logic [9:0] rows [7] = '{{9'h085, 1'b0}, {9'h087, 1'b0}, {9'h08D, 1'b1}, {9'h195, 1'b0},
      {9'h0E5, 1'b0}, {9'h001, 1'b0}, {9'h095, 1'b0}};
   logic [7:0] data [3] = '{8'h7E, 8'hFF, 8'h01};
   hdlc_overhead_packet_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .tx_bit_req_i(req), .tx_bit_o(txb),
      .rx_bit_valid_i(rxv), .rx_bit_i(rxb), .rx_buffer_byte_o(rbyte), .rx_valid_o(vld),
      .rx_start_o(st), .rx_end_o(en), .rx_abort_o(ab), .rx_fcs_err_o(fe));
   framer_link_model u_link (.clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .line_i(txb),
      .req_o(req), .rxv_o(rxv), .rxb_o(rxb));
   always #50 clk_i = ~clk_i;
   task final_report();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (vld === 1'b1) q.push_back({fe, ab, en, st, rbyte});
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) error_cnt++;
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task waitq();
      int n;
      n = 0;
      while (!(q.size() > 0 && q[$][9] === 1'b1) && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   function logic [7:0] rev(input logic [7:0] b);
      return {<<{b}};
   endfunction
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         wb(8'h00, 1'b1, {23'h0, rows[i][9:1]});
         repeat (40) @(posedge clk_i);
         q.delete();
         for (int k = 0; k < 3; k++) wb(8'h08, 1'b1, {23'h0, k == 2, data[k]});
         waitq();
         chk("count", q.size(), 3);
         for (int k = 0; k < 3; k++) begin
            e = {rows[i][0] && k == 2, 1'b0, k == 2, k == 0, data[k]};
            if (rows[i][5] ^ rows[i][9]) e[7:0] = rev(data[k]);
            chk("rxbyte", q[k], e);
         end
      end
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(8'h00, 1'b0, 32'h0); chk("ctrl", r, 32'h0);
      wb(8'h04, 1'b0, 32'h0); chk("thresh", r, 32'h10);
      wb(8'h10, 1'b0, 32'h0); chk("unmapped", r, 32'h0);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h5);
      gap <= 4'h3;
      q.delete();
      wb(8'h00, 1'b1, 32'h5);
      wb(8'h08, 1'b1, 32'h11);
      wb(8'h08, 1'b1, 32'h22);
      // Byte pending when the abort arrives is dropped, so a third one releases 11h
      wb(8'h08, 1'b1, 32'h33);
      waitq();
      chk("first", q[0], 12'h111);
      chk("abort", q[$], 12'h600);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h15);
      wb(8'h0C, 1'b1, 32'h10);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h5);
      wb(8'h00, 1'b1, 32'h0);
      for (int k = 0; k < 256; k++) wb(8'h08, 1'b1, k);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h10002);
      wb(8'h08, 1'b1, 32'h0);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h1000A);
      wb(8'h04, 1'b1, 32'h0);
      wb(8'h0C, 1'b0, 32'h0); chk("status", r, 32'h1000E);
      final_report();
   end
endmodule // hdlc_overhead_packet_controller_tb
`default_nettype wire
